/* hdl/rvtf_pkg.sv */
// constants shared by the rom vector and table fetch block
package rvtf_pkg;
	// program memory map
	localparam logic [15:0] RESET_VECTOR   = 16'h0000;
	localparam logic [15:0] IRQ_VECTOR     = 16'h0008;
	localparam int          ROM_WORDS      = 4096;
	localparam int          RESERVED_WORDS = 4;

	// register byte offsets
	localparam logic [7:0] REG_PC      = 8'h00;
	localparam logic [7:0] REG_ACC     = 8'h04;
	localparam logic [7:0] REG_FLAGS   = 8'h08;
	localparam logic [7:0] REG_PTR_HI  = 8'h0c;
	localparam logic [7:0] REG_PTR_LO  = 8'h10;
	localparam logic [7:0] REG_RES_HI  = 8'h14;
	localparam logic [7:0] REG_CTRL    = 8'h18;
	localparam logic [7:0] REG_STATUS  = 8'h1c;

	// program_flag_register layout
	localparam int         FLAG_A_BIT   = 7;
	localparam int         FLAG_B_BIT   = 6;
	localparam logic [7:0] FLAG_SW_MASK = 8'h07;
	localparam logic [7:0] FLAG_RC_MASK = 8'hc0;

	// control register command bits
	localparam int CTRL_PUSH_BIT      = 0;
	localparam int CTRL_POP_BIT       = 1;
	localparam int CTRL_FETCH_BIT     = 2;
	localparam int CTRL_INC_LO_BIT    = 3;
	localparam int CTRL_INT_RET_BIT   = 4;

	// status register bits
	localparam int STAT_BUSY_BIT      = 0;
	localparam int STAT_SAVED_BIT     = 1;
	localparam int STAT_EMPTY_BIT     = 2;
	localparam int STAT_FULL_BIT      = 3;
	localparam int STAT_RSV_ERR_BIT   = 4;
	localparam int STAT_STK_ERR_BIT   = 5;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// table fetch sequencer
	typedef enum logic [1:0] {
		FS_IDLE,
		FS_ISSUE,
		FS_LOAD
	} rvtf_fsm_t;
endpackage

/* hdl/rvtf_core.sv */
// program counter, vectors, save buffer and rom table fetch with axi4-lite registers
//
// Function
// - any reset loads pc with 0000h and all registers with defaults
// - reset cause flags: power-on 1/0, watchdog 0/0, external 1/1
// - interrupt service pushes pc and continues at word 0008h
// - push/pop copy acc and flags, reset-cause flags left alone
// - save buffer holds one set; a second push overwrites it
// - table address: high pointer bits 8-15, low pointer bits 0-7
// - fetched low byte to acc, high byte to high result register
// - low pointer increment never carries into high pointer
// - top reserved rom words never become user program words
`timescale 1ns/1ps

module rvtf_core #(
	parameter int ROM_WORDS   = rvtf_pkg::ROM_WORDS,
	parameter int STACK_DEPTH = 4,
	parameter int AXI_AW      = 8
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// reset causes and interrupt
	input  wire logic              wdt_reset,
	input  wire logic              ext_reset_n,
	input  wire logic              irq_req,
	output logic                   irq_ack,
	// instruction sequencing
	input  wire logic              pc_step,
	output logic [$clog2(ROM_WORDS)-1:0] prog_counter,
	// rom table port
	output logic                   rom_en,
	output logic [$clog2(ROM_WORDS)-1:0] rom_addr,
	input  wire logic [15:0]       rom_rdata
);
	localparam int PC_W = $clog2(ROM_WORDS);
	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	localparam logic [PC_W-1:0] PC_RESET = PC_W'(rvtf_pkg::RESET_VECTOR);
	localparam logic [PC_W-1:0] PC_IRQ   = PC_W'(rvtf_pkg::IRQ_VECTOR);
	localparam logic [PC_W-1:0] USER_LAST =
		PC_W'(ROM_WORDS - 1 - rvtf_pkg::RESERVED_WORDS);
	localparam logic [SP_W-1:0] SP_FULL  = SP_W'(STACK_DEPTH);

	typedef struct packed {
		logic [PC_W-1:0]                  pc;
		logic [7:0]                       acc;
		logic [7:0]                       flags;
		logic [7:0]                       ptr_hi;
		logic [7:0]                       ptr_lo;
		logic [7:0]                       res_hi;
		logic [7:0]                       save_acc;
		logic [7:0]                       save_flags;
		logic                             save_valid;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [SP_W-1:0]                  sp;
		rvtf_pkg::rvtf_fsm_t              fsm;
		logic [PC_W-1:0]                  rom_addr;
		logic                             rom_en;
		logic                             irq_ack;
		logic                             rsv_err;
		logic                             stk_err;
	} rvtf_core_t;

	typedef struct packed {
		logic              aw_have;
		logic [AXI_AW-1:0] aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} rvtf_bus_t;

	typedef struct packed {
		rvtf_bus_t  b;
		rvtf_core_t c;
	} rvtf_state_t;

	rvtf_state_t     s_reg;
	rvtf_state_t     s_next;
	logic [31:0]     wr_word;
	logic [4:0]      cmd;
	logic [15:0]     tbl_full;
	logic [PC_W-1:0] tbl_addr;

	// defaults for one reset cause; flags tell software who reset us
	function automatic rvtf_core_t core_default(input logic fa, input logic fb);
		rvtf_core_t c;
		c = '0;
		c.pc = PC_RESET;
		c.fsm = rvtf_pkg::FS_IDLE;
		c.flags[rvtf_pkg::FLAG_A_BIT] = fa;
		c.flags[rvtf_pkg::FLAG_B_BIT] = fb;
		return c;
	endfunction

	// word decode shared by read and write paths
	function automatic logic addr_hit(input logic [AXI_AW-1:0] a, input logic [7:0] off);
		return a[AXI_AW-1:2] == (AXI_AW-2)'(off >> 2);
	endfunction

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// sequential pc; running off user code restarts at the reset vector
	function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] p);
		if (p >= USER_LAST) begin
			return PC_RESET;
		end
		return PC_W'(p + 1'b1);
	endfunction

	// table address, only the implemented rom range is used
	assign tbl_full = {s_reg.c.ptr_hi, s_reg.c.ptr_lo};
	assign tbl_addr = tbl_full[PC_W-1:0];

	// handshake outputs straight from the holding flags
	assign s_axi_awready = !s_reg.b.aw_have && !s_reg.b.bvalid;
	assign s_axi_wready  = !s_reg.b.w_have && !s_reg.b.bvalid;
	assign s_axi_arready = !s_reg.b.rvalid;
	assign s_axi_bvalid  = s_reg.b.bvalid;
	assign s_axi_bresp   = s_reg.b.bresp;
	assign s_axi_rvalid  = s_reg.b.rvalid;
	assign s_axi_rdata   = s_reg.b.rdata;
	assign s_axi_rresp   = s_reg.b.rresp;
	assign irq_ack       = s_reg.c.irq_ack;
	assign prog_counter  = s_reg.c.pc;
	assign rom_en        = s_reg.c.rom_en;
	assign rom_addr      = s_reg.c.rom_addr;

	// next state of bus slave and core
	always_comb begin
		s_next = s_reg;
		wr_word = '0;
		cmd = '0;
		s_next.c.irq_ack = 1'b0;
		s_next.c.rom_en = 1'b0;

		// instruction step first, a bus write of pc overrides it
		if (pc_step) begin
			s_next.c.pc = next_pc(s_reg.c.pc);
			if (s_reg.c.pc >= USER_LAST) begin
				s_next.c.rsv_err = 1'b1;
			end
		end

		// address and data are taken independently, in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.b.aw_have = 1'b1;
			s_next.b.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.b.w_have = 1'b1;
			s_next.b.w_data = s_axi_wdata;
			s_next.b.w_strb = s_axi_wstrb;
		end
		if (s_reg.b.bvalid && s_axi_bready) begin
			s_next.b.bvalid = 1'b0;
		end

		// register write once both halves are held
		if (s_reg.b.aw_have && s_reg.b.w_have) begin
			s_next.b.aw_have = 1'b0;
			s_next.b.w_have = 1'b0;
			s_next.b.bvalid = 1'b1;
			s_next.b.bresp = rvtf_pkg::RESP_OKAY;
			if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_PC)) begin
				wr_word = merge(32'(s_reg.c.pc), s_reg.b.w_data, s_reg.b.w_strb);
				// jumps into the reserved top words are refused
				if (wr_word[PC_W-1:0] > USER_LAST || wr_word[31:PC_W] != '0) begin
					s_next.c.rsv_err = 1'b1;
				end else begin
					s_next.c.pc = wr_word[PC_W-1:0];
				end
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_ACC)) begin
				wr_word = merge(32'(s_reg.c.acc), s_reg.b.w_data, s_reg.b.w_strb);
				s_next.c.acc = wr_word[7:0];
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_FLAGS)) begin
				// reset-cause bits are read only
				wr_word = merge(32'(s_reg.c.flags), s_reg.b.w_data, s_reg.b.w_strb);
				s_next.c.flags = (s_reg.c.flags & rvtf_pkg::FLAG_RC_MASK)
					| (wr_word[7:0] & rvtf_pkg::FLAG_SW_MASK);
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_PTR_HI)) begin
				wr_word = merge(32'(s_reg.c.ptr_hi), s_reg.b.w_data, s_reg.b.w_strb);
				s_next.c.ptr_hi = wr_word[7:0];
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_PTR_LO)) begin
				wr_word = merge(32'(s_reg.c.ptr_lo), s_reg.b.w_data, s_reg.b.w_strb);
				s_next.c.ptr_lo = wr_word[7:0];
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_RES_HI)) begin
				s_next.b.bresp = rvtf_pkg::RESP_OKAY; // read only, write dropped
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_CTRL)) begin
				wr_word = merge('0, s_reg.b.w_data, s_reg.b.w_strb);
				cmd = wr_word[4:0];
			end else if (addr_hit(s_reg.b.aw_addr, rvtf_pkg::REG_STATUS)) begin
				// write one to clear; events below are applied later and win
				wr_word = merge('0, s_reg.b.w_data, s_reg.b.w_strb);
				// a wrap by pc_step in this same cycle keeps the flag set
				if (wr_word[rvtf_pkg::STAT_RSV_ERR_BIT]
						&& !(pc_step && s_reg.c.pc >= USER_LAST)) begin
					s_next.c.rsv_err = 1'b0;
				end
				if (wr_word[rvtf_pkg::STAT_STK_ERR_BIT]) begin
					s_next.c.stk_err = 1'b0;
				end
			end else begin
				s_next.b.bresp = rvtf_pkg::RESP_SLVERR;
			end
		end

		// read channel
		if (s_reg.b.rvalid && s_axi_rready) begin
			s_next.b.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.b.rvalid = 1'b1;
			s_next.b.rresp = rvtf_pkg::RESP_OKAY;
			s_next.b.rdata = '0;
			if (addr_hit(s_axi_araddr, rvtf_pkg::REG_PC)) begin
				s_next.b.rdata = 32'(s_reg.c.pc);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_ACC)) begin
				s_next.b.rdata = 32'(s_reg.c.acc);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_FLAGS)) begin
				s_next.b.rdata = 32'(s_reg.c.flags);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_PTR_HI)) begin
				s_next.b.rdata = 32'(s_reg.c.ptr_hi);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_PTR_LO)) begin
				s_next.b.rdata = 32'(s_reg.c.ptr_lo);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_RES_HI)) begin
				s_next.b.rdata = 32'(s_reg.c.res_hi);
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_CTRL)) begin
				s_next.b.rdata = '0; // commands are strobes
			end else if (addr_hit(s_axi_araddr, rvtf_pkg::REG_STATUS)) begin
				s_next.b.rdata[rvtf_pkg::STAT_BUSY_BIT] = s_reg.c.fsm != rvtf_pkg::FS_IDLE;
				s_next.b.rdata[rvtf_pkg::STAT_SAVED_BIT] = s_reg.c.save_valid;
				s_next.b.rdata[rvtf_pkg::STAT_EMPTY_BIT] = s_reg.c.sp == '0;
				s_next.b.rdata[rvtf_pkg::STAT_FULL_BIT] = s_reg.c.sp == SP_FULL;
				s_next.b.rdata[rvtf_pkg::STAT_RSV_ERR_BIT] = s_reg.c.rsv_err;
				s_next.b.rdata[rvtf_pkg::STAT_STK_ERR_BIT] = s_reg.c.stk_err;
			end else begin
				s_next.b.rresp = rvtf_pkg::RESP_SLVERR;
			end
		end

		// table fetch sequencer: one cycle of rom latency
		case (s_reg.c.fsm)
			rvtf_pkg::FS_IDLE: begin
				// commands only start while idle; one per write, priority order
				if (cmd[rvtf_pkg::CTRL_INT_RET_BIT]) begin
					if (s_reg.c.sp == '0) begin
						s_next.c.stk_err = 1'b1;
					end else begin
						s_next.c.pc = s_reg.c.stack[s_reg.c.sp - 1'b1];
						s_next.c.sp = SP_W'(s_reg.c.sp - 1'b1);
					end
				end else if (cmd[rvtf_pkg::CTRL_PUSH_BIT]) begin
					// single slot, so a repeated push simply replaces it
					s_next.c.save_acc = s_reg.c.acc;
					s_next.c.save_flags = s_reg.c.flags & ~rvtf_pkg::FLAG_RC_MASK;
					s_next.c.save_valid = 1'b1;
				end else if (cmd[rvtf_pkg::CTRL_POP_BIT]) begin
					s_next.c.acc = s_reg.c.save_acc;
					s_next.c.flags = (s_reg.c.flags & rvtf_pkg::FLAG_RC_MASK)
						| (s_reg.c.save_flags & ~rvtf_pkg::FLAG_RC_MASK);
				end else if (cmd[rvtf_pkg::CTRL_FETCH_BIT]) begin
					s_next.c.rom_en = 1'b1;
					s_next.c.rom_addr = tbl_addr;
					s_next.c.fsm = rvtf_pkg::FS_ISSUE;
				end else if (cmd[rvtf_pkg::CTRL_INC_LO_BIT]) begin
					s_next.c.ptr_lo = 8'(s_reg.c.ptr_lo + 1'b1);
				end else if (irq_req && s_reg.c.sp != SP_FULL) begin
					// a full stack holds the request off until a return
					s_next.c.stack[s_reg.c.sp] = s_next.c.pc;
					s_next.c.sp = SP_W'(s_reg.c.sp + 1'b1);
					s_next.c.pc = PC_IRQ;
					s_next.c.irq_ack = 1'b1;
				end
			end
			rvtf_pkg::FS_ISSUE: begin
				s_next.c.fsm = rvtf_pkg::FS_LOAD;
			end
			rvtf_pkg::FS_LOAD: begin
				s_next.c.acc = rom_rdata[7:0];
				s_next.c.res_hi = rom_rdata[15:8];
				s_next.c.fsm = rvtf_pkg::FS_IDLE;
			end
			default: begin
				s_next.c.fsm = rvtf_pkg::FS_IDLE;
			end
		endcase

		// core resets leave a bus transfer in flight untouched
		if (!ext_reset_n) begin
			s_next.c = core_default(1'b1, 1'b1);
		end else if (wdt_reset) begin
			s_next.c = core_default(1'b0, 1'b0);
		end
	end

	// single state register; power-on reset marks flag a only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg.b <= '0;
			s_reg.c <= core_default(1'b1, 1'b0);
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

/* verification/rvtf_core_properties.sv */
// concurrent checks on the ports of the rom vector and table fetch core
`timescale 1ns/1ps
module rvtf_core_properties #(
	parameter int ROM_WORDS = rvtf_pkg::ROM_WORDS,
	parameter int AXI_AW    = 8
) (
	// clock and reset
	input wire logic                         aclk,
	input wire logic                         aresetn,
	// bus handshakes
	input wire logic                         s_axi_awvalid,
	input wire logic                         s_axi_awready,
	input wire logic                         s_axi_wvalid,
	input wire logic                         s_axi_wready,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_arvalid,
	input wire logic                         s_axi_arready,
	input wire logic                         s_axi_rvalid,
	// core side
	input wire logic                         wdt_reset,
	input wire logic                         ext_reset_n,
	input wire logic                         irq_ack,
	input wire logic [$clog2(ROM_WORDS)-1:0] prog_counter,
	input wire logic                         rom_en,
	input wire logic [$clog2(ROM_WORDS)-1:0] rom_addr
);
	// last word that software may run from; the rest is reserved
	localparam int LAST_USER = ROM_WORDS - rvtf_pkg::RESERVED_WORDS - 1;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// a table read is one strobe followed by the load cycle
	sequence s_fetch_issue;
		rom_en;
	endsequence
	sequence s_fetch_load;
		!rom_en ##1 !rom_en;
	endsequence
	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_fetch_pulse: assert property (s_fetch_issue |=> s_fetch_load)
		else $error("rom strobe not a single pulse");
	a_ext_default: assert property (!ext_reset_n |=> prog_counter == 0 && !rom_en && !irq_ack)
		else $error("external reset left core state");
	a_wdt_default: assert property (wdt_reset && ext_reset_n |=> prog_counter == 0 && !irq_ack)
		else $error("watchdog reset left core state");
	a_irq_vector: assert property (irq_ack |-> prog_counter == rvtf_pkg::IRQ_VECTOR[11:0])
		else $error("interrupt entry not at vector");
	a_pc_user: assert property (prog_counter <= LAST_USER)
		else $error("pc inside reserved words");
	a_rom_hold: assert property (ext_reset_n && !wdt_reset |=> rom_en || $stable(rom_addr))
		else $error("table address moved without a fetch");
	a_write_answer: assert property (s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response timing");
endmodule

bind rvtf_core rvtf_core_properties #(.ROM_WORDS(ROM_WORDS), .AXI_AW(AXI_AW)) u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .wdt_reset(wdt_reset), .ext_reset_n(ext_reset_n),
	.irq_ack(irq_ack), .prog_counter(prog_counter), .rom_en(rom_en), .rom_addr(rom_addr));

/* verification/rvtf_rom_model.sv */
// program rom model with one cycle of read latency
`timescale 1ns/1ps
module rvtf_rom_model (
	// clock
	input wire logic        aclk,
	// table port
	input wire logic        rom_en,
	input wire logic [11:0] rom_addr,
	output logic     [15:0] rom_rdata
);
	// contents derive from the 4096-word address; outside a read the data
	// toggles so a late sample never sees a stale word
	always_ff @(posedge aclk) begin
		if (rom_en)
			rom_rdata <= {rom_addr[11:4] ^ 8'ha5, rom_addr[7:0] ^ 8'h5a};
		else
			rom_rdata <= ~rom_rdata;
	end
endmodule

/* verification/rvtf_core_tb_top.sv */
// self-checking bench for the rom vector and table fetch core
`timescale 1ns/1ps
module rvtf_core_tb_top;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, wdt_reset, ext_reset_n, irq_req, irq_ack, pc_step, rom_en;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, hi, lo;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [11:0] prog_counter, rom_addr, p;
	logic [15:0] rom_rdata, word;
	logic [7:0]  sv_acc, sv_flg;
	int          fail_count, check_count, n;
	int          stk[$];

	rvtf_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .wdt_reset(wdt_reset), .ext_reset_n(ext_reset_n),
		.irq_req(irq_req), .irq_ack(irq_ack), .pc_step(pc_step), .prog_counter(prog_counter),
		.rom_en(rom_en), .rom_addr(rom_addr), .rom_rdata(rom_rdata));
	rvtf_rom_model u_rom (.aclk(aclk), .rom_en(rom_en), .rom_addr(rom_addr), .rom_rdata(rom_rdata));

	// 100 mhz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axi_wr(a, v, rs);
		chk_resp("bresp", rvtf_pkg::RESP_OKAY, rs);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0]  rs;
		axi_rd(a, v, rs);
		chk(what, exp, v);
		chk_resp("rresp", rvtf_pkg::RESP_OKAY, rs);
	endtask
	// one cycle of an external (0) or watchdog (1) reset
	task automatic core_reset(input int kind);
		@(posedge aclk);
		ext_reset_n <= (kind != 0);
		wdt_reset <= (kind == 1);
		@(posedge aclk);
		ext_reset_n <= 1'b1;
		wdt_reset <= 1'b0;
	endtask

	// hang guard, well above the length of the sequence
	initial begin
		#300000;
		fail_count++;
		stop_test();
	end

	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, wdt_reset, irq_req, pc_step} = '0;
		s_axi_wstrb = 4'hf;
		ext_reset_n = 1'b1;
		aresetn = 1'b0;
		void'($urandom(32'hf5a6));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("pc", rvtf_pkg::REG_PC, 32'h0);
		rd_chk("flags", rvtf_pkg::REG_FLAGS, 32'h80);
		// external then watchdog cause, each clearing a dirty accumulator
		for (int i = 0; i < 2; i++) begin
			wr(rvtf_pkg::REG_ACC, 32'($urandom_range(255, 1)));
			wr(rvtf_pkg::REG_PC, 32'h123);
			core_reset(i);
			rd_chk("flags", rvtf_pkg::REG_FLAGS, (i == 0) ? 32'hc0 : 32'h00);
			rd_chk("acc", rvtf_pkg::REG_ACC, 32'h0);
			rd_chk("pc", rvtf_pkg::REG_PC, 32'h0);
		end
		// table reads, first one at the low pointer wrap
		for (int i = 0; i < 4; i++) begin
			hi = 8'($urandom);
			lo = (i == 0) ? 8'hff : 8'($urandom);
			wr(rvtf_pkg::REG_PTR_HI, {24'h0, hi});
			wr(rvtf_pkg::REG_PTR_LO, {24'h0, lo});
			wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_FETCH_BIT);
			n = 0;
			do begin
				axi_rd(rvtf_pkg::REG_STATUS, d, r);
				n++;
			end while (d[rvtf_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
			chk("busy", 32'h0, {31'h0, d[rvtf_pkg::STAT_BUSY_BIT]});
			// rom model word at address {hi[3:0], lo}
			word = {hi[3:0] ^ 4'ha, lo[7:4] ^ 4'h5, lo ^ 8'h5a};
			rd_chk("acc", rvtf_pkg::REG_ACC, {24'h0, word[7:0]});
			rd_chk("res_hi", rvtf_pkg::REG_RES_HI, {24'h0, word[15:8]});
			wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_INC_LO_BIT);
			rd_chk("ptr_lo", rvtf_pkg::REG_PTR_LO, {24'h0, lo + 8'h01});
			rd_chk("ptr_hi", rvtf_pkg::REG_PTR_HI, {24'h0, hi});
		end
		// two saves then one restore; cause bits come from the external reset
		core_reset(0);
		for (int i = 0; i < 2; i++) begin
			sv_acc = 8'($urandom);
			sv_flg = 8'($urandom);
			wr(rvtf_pkg::REG_ACC, {24'h0, sv_acc});
			wr(rvtf_pkg::REG_FLAGS, {24'h0, sv_flg});
			wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_PUSH_BIT);
		end
		wr(rvtf_pkg::REG_ACC, {24'h0, ~sv_acc});
		wr(rvtf_pkg::REG_FLAGS, {24'h0, ~sv_flg});
		wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_POP_BIT);
		rd_chk("acc", rvtf_pkg::REG_ACC, {24'h0, sv_acc});
		rd_chk("flags", rvtf_pkg::REG_FLAGS, {24'h0, 8'hc0 | (sv_flg & 8'h07)});
		// save valid and stack empty, nothing else pending
		rd_chk("status", rvtf_pkg::REG_STATUS, 32'h06);
		// interrupt entry after three steps, then return
		p = 12'($urandom_range(12'hff0, 12'h010));
		wr(rvtf_pkg::REG_PC, {20'h0, p});
		@(posedge aclk);
		pc_step <= 1'b1;
		repeat (3) @(posedge aclk);
		pc_step <= 1'b0;
		irq_req <= 1'b1;
		stk.push_back(p + 12'h003);
		@(posedge aclk);
		irq_req <= 1'b0;
		n = 0;
		while (irq_ack !== 1'b1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		chk("irq_ack", 32'h1, {31'h0, irq_ack});
		rd_chk("pc", rvtf_pkg::REG_PC, 32'h008);
		wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_INT_RET_BIT);
		rd_chk("pc", rvtf_pkg::REG_PC, 32'(stk.pop_back()));
		// reserved words refused, last user word wraps
		wr(rvtf_pkg::REG_PC, 32'hffb);
		axi_wr(rvtf_pkg::REG_PC, 32'hffc, r);
		chk_resp("bresp", rvtf_pkg::RESP_OKAY, r);
		rd_chk("pc", rvtf_pkg::REG_PC, 32'hffb);
		@(posedge aclk);
		pc_step <= 1'b1;
		@(posedge aclk);
		pc_step <= 1'b0;
		rd_chk("pc", rvtf_pkg::REG_PC, 32'h0);
		// return on an empty stack is flagged, pc stays
		wr(rvtf_pkg::REG_CTRL, 32'h1 << rvtf_pkg::CTRL_INT_RET_BIT);
		axi_rd(rvtf_pkg::REG_STATUS, d, r);
		chk("rsv_err", 32'h1, {31'h0, d[rvtf_pkg::STAT_RSV_ERR_BIT]});
		chk("status", 32'h36, d);
		rd_chk("pc", rvtf_pkg::REG_PC, 32'h0);
		// write one clears both sticky bits
		wr(rvtf_pkg::REG_STATUS, 32'h30);
		rd_chk("status", rvtf_pkg::REG_STATUS, 32'h06);
		// unmapped offset
		axi_wr(8'h20, 32'h5a, r);
		chk_resp("bresp", rvtf_pkg::RESP_SLVERR, r);
		axi_rd(8'h20, d, r);
		chk_resp("rresp", rvtf_pkg::RESP_SLVERR, r);
		stop_test();
	end
endmodule
